// ==== logic/motion_report_registers.v ====
// Behaviour
// - I2C slave at seven-bit address 0x10
// - Eight-bit register index decode
// - Pin control bit0 forces indication high
// - Pin control bit1 reads sleep input
// - Pin control bit2 selects indication polarity
// - Pin control bit3 selects open-drain drive
// - Clear bit0 subtracts reported value
// - Clear bit1 enables clear-on-read
// - X displacement read-only signed byte
// - Y displacement read-only signed byte
// - Overflow flags for X and Y limits
// - No-movement flag set at poll
// - Direction bits invert X and Y
// - Direction bit3 swaps X and Y
// - Low feature count zeroes displacement
// - Hardware revision RO, firmware revision RW
// - Search vector register sets sensitivity
// - Read with auto-clear zeroes the axis read, deasserts indication once X and Y are both zero
// - Index auto-increments after each byte
// - Accumulates motion only while sleep input low
`timescale 1ns/1ps
`include "motion_report_map.vh"

module motion_report_registers #(
  parameter [7:0] HW_REVISION = 8'h5A  // Arbitrary value
) (
  // Clock and reset
  input  wire        clk_i,
  input  wire        nrst_i,
  // I2C lines
  input  wire        scl_i,
  input  wire        sda_i,
  output reg         sda_o,
  output reg         sda_oe_o,
  // Motion engine side
  input  wire        move_valid_i,
  input  wire [7:0]  move_dx_i,
  input  wire [7:0]  move_dy_i,
  input  wire [13:0] feature_count_i,
  output reg  [7:0]  search_vector_o,
  // Sleep and indication pins
  input  wire        sleep_input_pin_i,
  output reg         indication_o,
  output reg         indication_oe_o,
  output reg         engine_run_o
);

  // ----------------------------------------
  // Protocol states
  // ----------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;  // Waiting for start
  localparam [2:0] ST_ADDR = 3'h1;  // Receiving address byte
  localparam [2:0] ST_AACK = 3'h2;  // Driving address ack
  localparam [2:0] ST_WR   = 3'h3;  // Receiving write byte
  localparam [2:0] ST_WACK = 3'h4;  // Driving write ack
  localparam [2:0] ST_RD   = 3'h5;  // Sending read byte
  localparam [2:0] ST_RACK = 3'h6;  // Sampling master ack

  reg [2:0] state;       // Protocol state
  reg [3:0] bit_cnt;     // Bits in current byte
  reg [7:0] shift;       // Receive/transmit shifter
  reg       idx_loaded;  // Index byte already received
  reg       ack_seen;    // Ack clock high seen

  // Registers
  reg [7:0] index;        // Register index
  reg [3:0] fw_rev;       // Firmware revision
  reg [3:0] pin_ctrl;     // Pin control writable bits
  reg [1:0] acc_clear;    // Clear register
  reg [3:0] orient;       // Axis orientation
  reg [7:0] feat_thr;     // Feature threshold
  reg       idle_flag;    // No movement at poll
  reg       sleep_q;      // Registered sleep level

  // Event strobes
  reg       drain_pulse;  // Drain request
  reg       clr_x;        // Clear-on-read X
  reg       clr_y;        // Clear-on-read Y
  reg [7:0] rd_data;      // Read multiplexer

  wire       scl_rise;
  wire       scl_fall;
  wire       start_cond;
  wire       stop_cond;
  wire       sda_s;
  wire [7:0] acc_x;
  wire [7:0] acc_y;
  wire       ovf_x;
  wire       ovf_y;

  // ----------------------------------------
  // Line sampling
  // ----------------------------------------
  bit_sampler u_sampler (
    .clk_i      (clk_i),
    .nrst_i     (nrst_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .scl_rise_o (scl_rise),
    .scl_fall_o (scl_fall),
    .start_o    (start_cond),
    .stop_o     (stop_cond),
    .sda_o      (sda_s)
  );

  // ----------------------------------------
  // Motion conditioning
  // ----------------------------------------
  reg  [7:0] dx_inv;   // X after inversion
  reg  [7:0] dy_inv;   // Y after inversion
  reg  [7:0] dx_rep;   // X as reported
  reg  [7:0] dy_rep;   // Y as reported
  reg        feat_ok;  // Enough surface features

  // Invert, swap and qualify incoming movement
  always @* begin
    dx_inv = orient[`ORI_INVX_BIT] ? (8'h00 - move_dx_i) : move_dx_i;
    dy_inv = orient[`ORI_INVY_BIT] ? (8'h00 - move_dy_i) : move_dy_i;
    dx_rep = orient[`ORI_SWAP_BIT] ? dy_inv : dx_inv;
    dy_rep = orient[`ORI_SWAP_BIT] ? dx_inv : dy_inv;
    feat_ok = (feature_count_i[13:6] >= feat_thr);
  end

  wire run = ~sleep_q;
  wire add = move_valid_i & feat_ok;

  motion_accumulator #(.W(8)) u_acc_x (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .run_i     (run),
    .add_i     (add),
    .delta_i   (dx_rep),
    .clear_i   (clr_x | ~feat_ok),
    .sub_i     (drain_pulse),
    .sub_val_i (acc_x),
    .acc_o     (acc_x),
    .ovf_o     (ovf_x)
  );

  motion_accumulator #(.W(8)) u_acc_y (
    .clk_i     (clk_i),
    .nrst_i    (nrst_i),
    .run_i     (run),
    .add_i     (add),
    .delta_i   (dy_rep),
    .clear_i   (clr_y | ~feat_ok),
    .sub_i     (drain_pulse),
    .sub_val_i (acc_y),
    .acc_o     (acc_y),
    .ovf_o     (ovf_y)
  );

  // ----------------------------------------
  // Read multiplexer
  // ----------------------------------------
  // Full eight-bit index decode
  always @* begin
    case (index)
      `IDX_HW_REV:     rd_data = HW_REVISION;
      `IDX_FW_REV:     rd_data = {4'h0, fw_rev};
      `IDX_PIN_CTRL:   rd_data = {4'h0, pin_ctrl[3:2], sleep_q, pin_ctrl[0]};
      `IDX_ACC_CLEAR:  rd_data = {6'h00, acc_clear};
      `IDX_HORIZ:      rd_data = acc_x;
      `IDX_VERT:       rd_data = acc_y;
      `IDX_FLAGS:      rd_data = {4'h0, idle_flag, 1'b0, ovf_y, ovf_x};
      `IDX_ORIENT:     rd_data = {4'h0, orient};
      `IDX_FEAT_THR:   rd_data = feat_thr;
      `IDX_SEARCH_MIN: rd_data = search_vector_o;
      default:         rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Serial protocol engine
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state           <= ST_IDLE;
      bit_cnt         <= 4'h0;
      shift           <= 8'h00;
      idx_loaded      <= 1'b0;
      ack_seen        <= 1'b0;
      index           <= 8'h00;
      fw_rev          <= `RST_FW_REV;
      pin_ctrl        <= `RST_PIN_CTRL;
      acc_clear       <= `RST_ACC_CLEAR;
      orient          <= `RST_ORIENT;
      feat_thr        <= `RST_FEAT_THR;
      search_vector_o <= `RST_SEARCH_MIN;
      idle_flag       <= 1'b0;
      drain_pulse     <= 1'b0;
      clr_x           <= 1'b0;
      clr_y           <= 1'b0;
      sda_o           <= 1'b0;
      sda_oe_o        <= 1'b0;
    end else begin
      drain_pulse <= 1'b0;
      clr_x       <= 1'b0;
      clr_y       <= 1'b0;
      if (start_cond) begin
        // Start or repeated start
        state    <= ST_ADDR;
        bit_cnt  <= 4'h0;
        sda_oe_o <= 1'b0;
      end else if (stop_cond) begin
        state    <= ST_IDLE;
        sda_oe_o <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          ST_ADDR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              if (shift[7:1] == `SLAVE_ADDR) begin
                state      <= ST_AACK;
                sda_oe_o   <= 1'b1;
                idx_loaded <= shift[0] ? idx_loaded : 1'b0;
                ack_seen   <= 1'b0;
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_AACK, ST_WACK: begin
            if (scl_rise)
              ack_seen <= 1'b1;
            if (scl_fall && ack_seen) begin
              bit_cnt  <= 4'h0;
              ack_seen <= 1'b0;
              if (state == ST_AACK && shift[0]) begin
                state    <= ST_RD;
                shift    <= rd_data;
                sda_oe_o <= ~rd_data[7];
                // Poll of X with nothing pending
                if (index == `IDX_HORIZ)
                  idle_flag <= (acc_x == 8'h00) && (acc_y == 8'h00);
              end else begin
                state    <= ST_WR;
                sda_oe_o <= 1'b0;
              end
            end
          end
          ST_WR: begin
            if (scl_rise) begin
              shift   <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end else if (scl_fall && bit_cnt == 4'h8) begin
              state    <= ST_WACK;
              sda_oe_o <= 1'b1;
              if (!idx_loaded) begin
                index      <= shift;
                idx_loaded <= 1'b1;
              end else begin
                index <= index + 8'h01;
                case (index)
                  `IDX_FW_REV:     fw_rev <= shift[3:0];
                  `IDX_PIN_CTRL:   pin_ctrl <= {shift[3:2], 1'b0, shift[0]};
                  `IDX_ACC_CLEAR: begin
                    acc_clear <= shift[1:0];
                    drain_pulse <= shift[`CLR_DRAIN_BIT];
                  end
                  `IDX_ORIENT:     orient <= {shift[3], 1'b0, shift[1:0]};
                  `IDX_FEAT_THR:   feat_thr <= shift;
                  `IDX_SEARCH_MIN: search_vector_o <= shift;
                  default:         fw_rev <= fw_rev;
                endcase
              end
            end
          end
          ST_RD: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                state    <= ST_RACK;
                sda_oe_o <= 1'b0;
                if (acc_clear[`CLR_AUTO_BIT]) begin
                  clr_x <= (index == `IDX_HORIZ);
                  clr_y <= (index == `IDX_VERT);
                end
                index <= index + 8'h01;
              end else begin
                shift    <= {shift[6:0], 1'b0};
                sda_oe_o <= ~shift[6];
                bit_cnt  <= bit_cnt + 4'h1;
              end
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              ack_seen <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (ack_seen) begin
                state    <= ST_RD;
                shift    <= rd_data;
                sda_oe_o <= ~rd_data[7];
              end else begin
                // Master nack ends read
                state <= ST_IDLE;
              end
            end
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Indication pin and sleep sampling
  // ----------------------------------------
  reg active;  // Pin level before drive style
  // Movement level at selected polarity, or forced high
  always @* begin
    active = ((acc_x != 8'h00) | (acc_y != 8'h00)) ^ pin_ctrl[`PIN_POL_BIT];
    // Force bit holds the pin high
    if (pin_ctrl[`PIN_FORCE_BIT])
      active = 1'b1;
  end

  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sleep_q         <= 1'b1;
      engine_run_o    <= 1'b0;
      indication_o    <= 1'b0;
      indication_oe_o <= 1'b1;
    end else begin
      sleep_q      <= sleep_input_pin_i;
      engine_run_o <= ~sleep_input_pin_i;
      // Registered pin level
      indication_o <= active;
      indication_oe_o <= pin_ctrl[`PIN_STYLE_BIT] ? ~active : 1'b1;
    end
  end

endmodule

// ==== shared/motion_report_map.vh ====
`ifndef MOTION_REPORT_MAP_VH
`define MOTION_REPORT_MAP_VH

// ----------------------------------------
// Bus addressing
// ----------------------------------------
`define SLAVE_ADDR        7'h10
`define MAX_SCL_KHZ       400

// ----------------------------------------
// Register indices
// ----------------------------------------
`define IDX_HW_REV        8'h00
`define IDX_FW_REV        8'h01
`define IDX_PIN_CTRL      8'h05
`define IDX_ACC_CLEAR     8'h20
`define IDX_HORIZ         8'h21
`define IDX_VERT          8'h22
`define IDX_FLAGS         8'h23
`define IDX_ORIENT        8'h27
`define IDX_FEAT_THR      8'h29
`define IDX_SEARCH_MIN    8'h2F

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PIN_FORCE_BIT     0
`define PIN_SLEEP_BIT     1
`define PIN_POL_BIT       2
`define PIN_STYLE_BIT     3
`define CLR_DRAIN_BIT     0
`define CLR_AUTO_BIT      1
`define FLG_XOVF_BIT      0
`define FLG_YOVF_BIT      1
`define FLG_IDLE_BIT      3
`define ORI_INVX_BIT      0
`define ORI_INVY_BIT      1
`define ORI_SWAP_BIT      3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_FW_REV        4'h0
`define RST_PIN_CTRL      4'h0
`define RST_ACC_CLEAR     2'h0
`define RST_ORIENT        4'hA
`define RST_FEAT_THR      8'h00
`define RST_SEARCH_MIN    8'h10

`endif

// ==== logic/bit_sampler.v ====
`timescale 1ns/1ps

// Edge finder for sampled SCL and SDA lines
module bit_sampler (
  // Clock and reset
  input  wire clk_i,
  input  wire nrst_i,
  // Lines
  input  wire scl_i,
  input  wire sda_i,
  // Events
  output reg  scl_rise_o,
  output reg  scl_fall_o,
  output reg  start_o,
  output reg  stop_o,
  output reg  sda_o
);

  reg scl_q;  // Previous SCL
  reg sda_q;  // Previous SDA

  // ----------------------------------------
  // Edge and condition detection
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q      <= 1'b1;
      sda_q      <= 1'b1;
      scl_rise_o <= 1'b0;
      scl_fall_o <= 1'b0;
      start_o    <= 1'b0;
      stop_o     <= 1'b0;
      sda_o      <= 1'b1;
    end else begin
      scl_q      <= scl_i;
      sda_q      <= sda_i;
      sda_o      <= sda_i;
      scl_rise_o <= scl_i & ~scl_q;
      scl_fall_o <= ~scl_i & scl_q;
      // SDA falls while SCL high
      start_o    <= scl_i & scl_q & sda_q & ~sda_i;
      // SDA rises while SCL high
      stop_o     <= scl_i & scl_q & ~sda_q & sda_i;
    end
  end

endmodule

// ==== logic/motion_accumulator.v ====
`timescale 1ns/1ps

// Saturating signed motion integrator for one axis
module motion_accumulator #(
  parameter W = 8
) (
  // Clock and reset
  input  wire         clk_i,
  input  wire         nrst_i,
  // Control
  input  wire         run_i,
  input  wire         add_i,
  input  wire [W-1:0] delta_i,
  input  wire         clear_i,
  input  wire         sub_i,
  input  wire [W-1:0] sub_val_i,
  // State
  output reg  [W-1:0] acc_o,
  output reg          ovf_o
);

  localparam signed [W:0] MAXV = {2'b00, {(W-1){1'b1}}};  // Positive limit
  localparam signed [W:0] MINV = {2'b11, {(W-1){1'b0}}};  // Negative limit

  reg signed [W+1:0] sum;  // Wide sum before saturation

  // ----------------------------------------
  // Next sum
  // ----------------------------------------
  always @* begin
    sum = {{2{acc_o[W-1]}}, acc_o};
    if (sub_i)
      sum = sum - {{2{sub_val_i[W-1]}}, sub_val_i};
    if (add_i && run_i)
      sum = sum + {{2{delta_i[W-1]}}, delta_i};
  end

  // ----------------------------------------
  // Accumulator with saturation
  // ----------------------------------------
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_o <= {W{1'b0}};
      ovf_o <= 1'b0;
    end else if (clear_i && !(add_i && run_i)) begin
      acc_o <= {W{1'b0}};
      ovf_o <= 1'b0;
    end else if (clear_i) begin
      // Movement arriving with clear is kept
      acc_o <= delta_i;
      ovf_o <= 1'b0;
    end else if (sum > MAXV) begin
      acc_o <= MAXV[W-1:0];
      ovf_o <= 1'b1;
    end else if (sum < MINV) begin
      acc_o <= MINV[W-1:0];
      ovf_o <= 1'b1;
    end else begin
      acc_o <= sum[W-1:0];
    end
  end

endmodule

// ==== verification/motion_report_monitor.sv ====
`timescale 1ns/1ps

// ----------------------------------------
// Port checker for the register bank
// ----------------------------------------
module motion_report_monitor (
  // Clock and reset
  input wire        clk_i,
  input wire        nrst_i,
  // I2C lines
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe_o,
  // Motion engine side
  input wire        move_valid_i,
  input wire [7:0]  move_dx_i,
  input wire [7:0]  move_dy_i,
  input wire [13:0] feature_count_i,
  input wire [7:0]  search_vector_o,
  // Sleep and indication pins
  input wire        sleep_input_pin_i,
  input wire        indication_o,
  input wire        indication_oe_o,
  input wire        engine_run_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  logic        scl_q;    // Last SCL sample
  logic [3:0]  quiet;    // Cycles since SCL moved, saturating
  logic [13:0] count_q;  // Last feature count
  logic [3:0]  recent;   // Recent motion or count events

  // Activity trackers for cause checks
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scl_q   <= 1'b1;
      quiet   <= 4'h0;
      count_q <= 14'h0000;
      recent  <= 4'h0;
    end else begin
      scl_q   <= scl_i;
      quiet   <= (scl_i != scl_q) ? 4'h0 : quiet + {3'h0, quiet != 4'hF};
      count_q <= feature_count_i;
      recent  <= {recent[2:0], move_valid_i | (feature_count_i != count_q)};
    end
  end

  a_sda_pulls_low: assert property (sda_oe_o |-> !sda_o)
    else $error("data line driven to a high level");
  a_sda_moves_low: assert property ($changed(sda_oe_o) |-> !scl_i && quiet < 4'h6)
    else $error("data drive changed away from a clock fall");
  a_ack_holds_bit: assert property ($rose(sda_oe_o) |-> sda_oe_o [*8])
    else $error("data drive dropped within a bit");
  a_start_stays_free: assert property (scl_i && $past(scl_i) && $fell(sda_i) |-> !sda_oe_o)
    else $error("data line driven during a start");
  a_run_tracks_sleep: assert property ($changed(sleep_input_pin_i) |-> ##[1:2] (engine_run_o == !sleep_input_pin_i))
    else $error("run output ignored sleep input");
  a_sleep_holds_pin: assert property (sleep_input_pin_i && $past(sleep_input_pin_i) && move_valid_i
    && quiet == 4'hF |=> $stable({indication_o, indication_oe_o}) [*4])
    else $error("motion while asleep moved the pin");
  a_pin_has_cause: assert property ($changed({indication_o, indication_oe_o}) |-> quiet < 4'h8 || recent != 4'h0)
    else $error("movement pin changed without a cause");
  a_vector_quiet: assert property (quiet > 4'h4 |-> $stable(search_vector_o))
    else $error("search vector changed with the bus idle");
endmodule

bind motion_report_registers motion_report_monitor u_monitor (
  .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
  .move_valid_i(move_valid_i), .move_dx_i(move_dx_i), .move_dy_i(move_dy_i),
  .feature_count_i(feature_count_i), .search_vector_o(search_vector_o),
  .sleep_input_pin_i(sleep_input_pin_i), .indication_o(indication_o),
  .indication_oe_o(indication_oe_o), .engine_run_o(engine_run_o)
);

// ==== verification/i2c_master_model.sv ====
`timescale 1ns/1ps
`include "motion_report_map.vh"

// ----------------------------------------
// Bus master standing in for the host
// ----------------------------------------
module i2c_master_model (
  // Clock
  input  wire  clk_i,
  // Resolved data line
  input  wire  sda_i,
  // Driven lines, high means released
  output logic scl_o,
  output logic sda_o
);
  // Bit period of 630 cycles stays under 400 kHz
  localparam int HALF = 313;

  // Lines released at time zero
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Wait on falling clock edges
  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // Start or repeated start
  task automatic start_cond;
    sda_o = 1'b1;
    pause(HALF);
    scl_o = 1'b1;
    pause(HALF);
    sda_o = 1'b0;
    pause(HALF);
    scl_o = 1'b0;
  endtask

  // Stop, data rises while clock high
  task automatic stop_cond;
    pause(4);
    sda_o = 1'b0;
    pause(HALF);
    scl_o = 1'b1;
    pause(HALF);
    sda_o = 1'b1;
    pause(HALF);
  endtask

  // One bit, data set while clock low, sampled mid high
  task automatic clock_bit(input logic b, output logic seen);
    pause(4);
    sda_o = b;
    pause(HALF);
    scl_o = 1'b1;
    pause(HALF / 2);
    seen = sda_i;
    pause(HALF - HALF / 2);
    scl_o = 1'b0;
  endtask

  // Eight bits MSB first, then the acknowledge slot
  task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      clock_bit(tx[i], rx[i]);
    end
    clock_bit(ack_bit, ack);
  endtask

  // Single register write, ok when all bytes acknowledged
  task automatic reg_write(input logic [7:0] idx, input logic [7:0] val, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2;
    start_cond;
    xfer({`SLAVE_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(idx, 1'b1, rx, a1);
    xfer(val, 1'b1, rx, a2);
    stop_cond;
    ok = !(a0 | a1 | a2);
  endtask

  // Index then repeated start, all bytes in one transfer
  task automatic reg_read(input logic [7:0] idx, input int n, output logic [23:0] d, output logic ok);
    logic [7:0] rx;
    logic       a0, a1, a2, unused;
    start_cond;
    xfer({`SLAVE_ADDR, 1'b0}, 1'b1, rx, a0);
    xfer(idx, 1'b1, rx, a1);
    start_cond;
    xfer({`SLAVE_ADDR, 1'b1}, 1'b1, rx, a2);
    d = 24'h000000;
    for (int i = 0; i < n; i++) begin
      xfer(8'hFF, i == n - 1, rx, unused);
      d = {d[15:0], rx};
    end
    stop_cond;
    ok = !(a0 | a1 | a2);
  endtask
endmodule

// ==== verification/motion_report_registers_tb.sv ====
`timescale 1ns/1ps
`include "motion_report_map.vh"

`define CHECK(what, exp, got) \
  begin \
    check_count = check_count + 1; \
    if ((got) !== (exp)) begin \
      n_fail = n_fail + 1; \
      $display("MISMATCH %s expected %h seen %h", what, exp, got); \
    end \
  end

module motion_report_registers_tb;
  localparam logic [7:0] HW_REV = 8'hC3;  // Arbitrary revision code
  logic        clk_i = 1'b0;              // Core clock
  logic        nrst_i = 1'b0;             // Reset, active low
  logic        move_valid_i = 1'b0;       // Motion strobe
  logic [7:0]  move_dx_i = 8'h00;         // Raw X delta
  logic [7:0]  move_dy_i = 8'h00;         // Raw Y delta
  logic [13:0] feature_count_i = 14'h3FFF;  // Feature count
  logic        sleep_input_pin_i = 1'b0;  // Sleep pin
  wire         scl_line, master_sda, sda_o, sda_oe_o, indication_o, indication_oe_o, engine_run_o;
  wire  [7:0]  search_vector_o;
  wire         sda_line = master_sda & ~(sda_oe_o & ~sda_o);  // Pulled-up wire
  int          check_count = 0;
  int          n_fail = 0;

  always #2 clk_i = ~clk_i;

  motion_report_registers #(.HW_REVISION(HW_REV)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe_o), .move_valid_i(move_valid_i), .move_dx_i(move_dx_i), .move_dy_i(move_dy_i),
    .feature_count_i(feature_count_i), .search_vector_o(search_vector_o),
    .sleep_input_pin_i(sleep_input_pin_i), .indication_o(indication_o),
    .indication_oe_o(indication_oe_o), .engine_run_o(engine_run_o));

  i2c_master_model master (.clk_i(clk_i), .sda_i(sda_line), .scl_o(scl_line), .sda_o(master_sda));

  // Verdict and end of run
  task automatic wrap_up;
    if (n_fail == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One motion pulse, then settle
  task automatic pulse_move(input logic [7:0] dx, input logic [7:0] dy);
    @(negedge clk_i);
    move_dx_i    = dx;
    move_dy_i    = dy;
    move_valid_i = 1'b1;
    @(negedge clk_i);
    move_valid_i = 1'b0;
    repeat (6) @(negedge clk_i);
  endtask

  // Pin levels straight after reset
  task automatic check_reset;
    `CHECK("search vector", 8'h10, search_vector_o)
    `CHECK("run", 1'b1, engine_run_o)
    `CHECK("pin level", 1'b0, indication_o)
    `CHECK("pin drive", 1'b1, indication_oe_o)
  endtask

  // Motion while asleep, idle flag, revisions, foreign address
  task automatic check_sleep;
    logic [23:0] d;
    logic [7:0]  rx;
    logic        ok, ack;
    sleep_input_pin_i = 1'b1;
    repeat (4) @(negedge clk_i);
    `CHECK("run asleep", 1'b0, engine_run_o)
    pulse_move(8'h05, 8'h07);
    `CHECK("pin asleep", 1'b0, indication_o)
    master.reg_read(`IDX_HORIZ, 3, d, ok);
    `CHECK("read ack", 1'b1, ok)
    `CHECK("idle displacement", 16'h0000, d[23:8])
    `CHECK("idle flag", 1'b1, d[3])
    `CHECK("overflow flags", 2'b00, d[1:0])
    master.reg_read(`IDX_HW_REV, 2, d, ok);
    `CHECK("revisions", {HW_REV, 4'h0}, {d[15:8], d[3:0]})
    sleep_input_pin_i = 1'b0;
    master.start_cond;
    master.xfer(8'h22, 1'b1, rx, ack);
    master.stop_cond;
    `CHECK("foreign address", 1'b1, ack)
  endtask

  // Drain empties both accumulators
  task automatic check_drain;
    logic ok;
    pulse_move(8'h03, 8'hFE);
    `CHECK("pin on motion", 1'b1, indication_o)
    master.reg_write(`IDX_ACC_CLEAR, 8'h03, ok);
    `CHECK("pin after drain", 1'b0, indication_o)
  endtask

  // Swap with both inversions, read clears
  task automatic check_orient;
    logic [23:0] d;
    logic        ok;
    master.reg_write(`IDX_ORIENT, 8'h0B, ok);
    pulse_move(8'h03, 8'hFE);
    master.reg_read(`IDX_HORIZ, 3, d, ok);
    `CHECK("reported x", 8'h02, d[23:16])
    `CHECK("reported y", 8'hFD, d[15:8])
    `CHECK("moving flag", 1'b0, d[3])
    `CHECK("pin after read", 1'b0, indication_o)
    `CHECK("read ack", 1'b1, ok)
  endtask

  // Feature threshold at and below its boundary
  task automatic check_threshold;
    logic ok;
    master.reg_write(`IDX_FEAT_THR, 8'h10, ok);
    feature_count_i = 14'h03FF;
    pulse_move(8'h05, 8'h05);
    `CHECK("pin below threshold", 1'b0, indication_o)
    feature_count_i = 14'h0400;
    pulse_move(8'h05, 8'h05);
    `CHECK("pin at threshold", 1'b1, indication_o)
  endtask

  // Polarity, drive style and forcing with motion pending
  task automatic check_pin;
    logic ok;
    master.reg_write(`IDX_PIN_CTRL, 8'h04, ok);
    `CHECK("low active level", 1'b0, indication_o)
    master.reg_write(`IDX_PIN_CTRL, 8'h0C, ok);
    `CHECK("open drain pulls", 1'b1, indication_oe_o)
    master.reg_write(`IDX_PIN_CTRL, 8'h09, ok);
    `CHECK("forced high released", 1'b0, indication_oe_o)
    `CHECK("write ack", 1'b1, ok)
  endtask

  // Search vector for idle and wake, sleep readback
  task automatic check_vector;
    logic [23:0] d;
    logic        ok;
    master.reg_write(`IDX_SEARCH_MIN, 8'h40, ok);
    `CHECK("idle vector", 8'h40, search_vector_o)
    sleep_input_pin_i = 1'b1;
    master.reg_read(`IDX_PIN_CTRL, 1, d, ok);
    `CHECK("pin control readback", 8'h0B, d[7:0])
    sleep_input_pin_i = 1'b0;
    master.reg_write(`IDX_SEARCH_MIN, 8'h10, ok);
    `CHECK("wake vector", 8'h10, search_vector_o)
  endtask

  // Main sequence
  initial begin
    repeat (8) @(negedge clk_i);
    nrst_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check_reset;
    check_sleep;
    check_drain;
    check_orient;
    check_threshold;
    check_pin;
    check_vector;
    wrap_up;
  end

  // Watchdog about 30 percent past the expected run length
  initial begin
    #1500000;
    n_fail = n_fail + 1;
    wrap_up;
  end
endmodule
